// ===== verilog/clc_pkg.sv
/*
 * Shared constants and types for the configurable logic cell:
 * register offsets, field positions, reset values and function codes.
 * Assumes a 32-bit APB bus with byte addresses on an 8-bit address.
 */
package clc_pkg;

    localparam int ADDR_W = 8;
    localparam int SEL_W = 6;
    localparam int NUM_SRC = 64;
    localparam int NUM_IN = 4;

    localparam logic [ADDR_W-1:0] OFS_CONTROL = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_POLARITY = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_INPUT_SEL0 = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_GATE_SEL0 = 8'h18;
    localparam logic [ADDR_W-1:0] OFS_IRQ_STATUS = 8'h28;
    localparam logic [ADDR_W-1:0] OFS_STRIDE = 8'h04;

    localparam int CTRL_ON_BIT = 7;
    localparam int CTRL_RESULT_BIT = 5;
    localparam int CTRL_RISE_BIT = 4;
    localparam int CTRL_FALL_BIT = 3;
    localparam int POL_RESULT_BIT = 7;
    localparam int STAT_FLAG_BIT = 0;

    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic POL_RESULT_RESET = 1'b0;
    localparam int APB_WAIT_CYCLES = 1;

    typedef enum logic [2:0] {
        FN_AND_OR = 3'b000,
        FN_OR_XOR = 3'b001,
        FN_AND4 = 3'b010,
        FN_SR_LATCH = 3'b011,
        FN_DFF_SR = 3'b100,
        FN_DFF2_R = 3'b101,
        FN_JK_R = 3'b110,
        FN_LATCH_SR = 3'b111
    } clc_func_t;

endpackage

// ===== verilog/clc_link_if.sv
/*
 * Internal bundle between the cell controller, the gate stage and the
 * function stage. Assumes all users share one clock domain.
 */
`timescale 1ns/100ps
interface clc_link_if;
    logic [3:0] data;
    logic [31:0] gate_en;
    logic [3:0] gate_inv;
    logic [3:0] gate;
    clc_pkg::clc_func_t mode;
    logic on;
    logic result;

    modport gate_mp (input data, input gate_en, input gate_inv, output gate);
    modport func_mp (input gate, input mode, input on, output result);
    modport ctl_mp (output data, output gate_en, output gate_inv, output mode,
        output on, input gate, input result);
endinterface

// ===== verilog/clc_gates.sv
/*
 * Data gating stage: four gates, each combining the enabled true or
 * negated data inputs, then its own output inversion.
 * Assumes a purely combinational path; no clock.
 */
`timescale 1ns/100ps
module clc_gates (
    clc_link_if.gate_mp link
);

    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : gate_blk
            logic [7:0] en;
            logic [3:0] term;
            assign en = link.gate_en[8*g +: 8];
            // [R17] odd bit true, even bit negated
            // [R18] input one at bits 1 and 0
            for (genvar i = 0; i < 4; i++) begin : term_blk
                assign term[i] = (en[2*i+1] & link.data[i]) | (en[2*i] & ~link.data[i]);
            end
            // [R19] enabled terms, then gate inversion
            // [R14] per-gate output inversion
            assign link.gate[g] = (|term) ^ link.gate_inv[g];
        end
    endgenerate

endmodule

// ===== verilog/clc_func.sv
/*
 * Logic function stage: eight combinational or sequential functions of
 * the four gate outputs. Gate 0 is the data-derived clock in modes 100 to 110 and the latch enable in mode 111.
 * Assumes gate outputs synchronous to the clock; synchronous reset.
 */
`timescale 1ns/100ps
module clc_func (
    input wire logic clk,
    input wire logic srst,
    clc_link_if.func_mp link
);

    typedef struct packed {
        logic q;
        logic clk_prev;
    } clc_func_state_t;

    clc_func_state_t s_q;
    clc_func_state_t s_d;

    logic [3:0] g;
    logic edge_hit;

    always_comb begin
        g = link.gate;
        edge_hit = g[0] & ~s_q.clk_prev;
        s_d = s_q;
        s_d.clk_prev = g[0];
        case (link.mode)
            // [R12] and-or
            clc_pkg::FN_AND_OR: s_d.q = (g[0] & g[1]) | (g[2] & g[3]);
            // [R11] or-xor
            clc_pkg::FN_OR_XOR: s_d.q = (g[0] | g[1]) ^ (g[2] | g[3]);
            // [R10] four-input and
            clc_pkg::FN_AND4: s_d.q = &g;
            // [R09] set-reset latch
            clc_pkg::FN_SR_LATCH: begin
                if (g[0] | g[1]) begin
                    s_d.q = 1'b1;
                end else if (g[2] | g[3]) begin
                    s_d.q = 1'b0;
                end
            end
            // [R08] d flip-flop, set and reset
            clc_pkg::FN_DFF_SR: begin
                if (g[2]) begin
                    s_d.q = 1'b0;
                end else if (g[3]) begin
                    s_d.q = 1'b1;
                end else if (edge_hit) begin
                    // [R24] state moves on gate clock
                    s_d.q = g[1];
                end
            end
            // [R07] two-data d flip-flop
            clc_pkg::FN_DFF2_R: begin
                if (g[2]) begin
                    s_d.q = 1'b0;
                end else if (edge_hit) begin
                    s_d.q = g[1] & g[3];
                end
            end
            // [R06] j-k flip-flop
            clc_pkg::FN_JK_R: begin
                if (g[2]) begin
                    s_d.q = 1'b0;
                end else if (edge_hit) begin
                    case ({g[1], g[3]})
                        2'b01: s_d.q = 1'b0;
                        2'b10: s_d.q = 1'b1;
                        2'b11: s_d.q = ~s_q.q;
                        default: s_d.q = s_q.q;
                    endcase
                end
            end
            // [R05] transparent latch, set and reset
            clc_pkg::FN_LATCH_SR: begin
                if (g[2]) begin
                    s_d.q = 1'b0;
                end else if (g[3]) begin
                    s_d.q = 1'b1;
                end else if (g[0]) begin
                    s_d.q = g[1];
                end
            end
            default: s_d.q = s_q.q;
        endcase
        if (!link.on) begin
            s_d.q = 1'b0;
        end
    end

    assign link.result = s_d.q;

    always_ff @(posedge clk) begin
        if (srst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

endmodule

// ===== verilog/clc_cell.sv
/*
 * Configurable logic cell top: APB register file, input source
 * selection, gate and function stages, output inversion and edge flag.
 * Assumes APB signals and source inputs synchronous to REF_CLK (40 MHz)
 * and a synchronous active-high reset on SRST.
 */
`timescale 1ns/100ps

// Function
// [R01] cell off forces output to zero
// [R02] control bit 5 reads inverted result
// [R03] rising output edge sets flag if enabled
// [R04] falling output edge sets flag if enabled
// [R05] mode 111 latch with set, reset
// [R06] mode 110 j-k flip-flop with reset
// [R07] mode 101 two-data d flip-flop, reset
// [R08] mode 100 d flip-flop, set, reset
// [R09] mode 011 set-reset latch
// [R10] mode 010 four-input and
// [R11] mode 001 or-xor of gates
// [R12] mode 000 and-or of gates
// [R13] polarity bit 7 inverts cell result
// [R14] polarity bits 3-0 invert each gate
// [R15] unused polarity, selector bits read zero
// [R16] six-bit source selector per input
// [R17] gate select pairs: odd true, even negated
// [R18] bits 1,0 gate input one
// [R19] gate combines enabled inputs, then inverts
// [R20] reset clears control only; the code also clears polarity bit 7
// [R21] software clears flag; set wins
// [R22] inversion change raises edge flag
// [R23] writes act next cycle; edge vs registered
// [R24] sequential state moves on gate clock
module clc_cell (
    input wire logic REF_CLK,
    input wire logic SRST,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic [3:0] PSTRB,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire logic [63:0] SRC_IN,
    output logic CELL_OUTPUT_SIGNAL,
    output logic CELL_IRQ_FLAG
);

    typedef struct packed {
        logic cell_on;
        logic rise_irq_en;
        logic fall_irq_en;
        clc_pkg::clc_func_t function_select;
        logic result_invert;
        logic [3:0] gate_invert;
        logic [3:0][5:0] input_source;
        logic [3:0][7:0] gate_select;
        logic cell_result;
        logic cell_irq_flag;
        logic [31:0] rdata;
        logic ready;
        logic slverr;
    } clc_cell_state_t;

    clc_cell_state_t s_q;
    clc_cell_state_t s_d;

    clc_link_if link ();

    wire [3:0] sel_data;

    logic access_phase;
    logic commit;
    logic do_write;
    logic hit;
    logic [31:0] rd_value;
    logic [7:0] wbyte;
    logic [7:0] rel;
    logic [1:0] idx;
    logic out_next;
    logic rise_evt;
    logic fall_evt;
    logic flag_clear;

    // [R16] per-input six-bit source selection
    genvar i;
    generate
        for (i = 0; i < 4; i++) begin : src_blk
            assign sel_data[i] = SRC_IN[s_q.input_source[i]];
        end
    endgenerate

    assign link.data = sel_data;
    assign link.gate_en = s_q.gate_select;
    assign link.gate_inv = s_q.gate_invert;
    assign link.mode = s_q.function_select;
    assign link.on = s_q.cell_on;

    clc_gates u_gates (
        .link(link.gate_mp)
    );

    clc_func u_func (
        .clk(REF_CLK),
        .srst(SRST),
        .link(link.func_mp)
    );

    always_comb begin
        s_d = s_q;
        access_phase = PSEL & PENABLE;
        commit = access_phase & s_q.ready;
        do_write = commit & PWRITE & PSTRB[0];
        wbyte = PWDATA[7:0];
        rel = PADDR - clc_pkg::OFS_INPUT_SEL0;
        idx = rel[3:2];
        hit = 1'b1;
        rd_value = 32'h0000_0000;
        flag_clear = 1'b0;

        // register read view and address decode
        if (PADDR[1:0] != 2'b00) begin
            hit = 1'b0;
        end else if (PADDR == clc_pkg::OFS_CONTROL) begin
            // [R02] result shown in bit 5
            rd_value[clc_pkg::CTRL_ON_BIT] = s_q.cell_on;
            rd_value[clc_pkg::CTRL_RESULT_BIT] = s_q.cell_result;
            rd_value[clc_pkg::CTRL_RISE_BIT] = s_q.rise_irq_en;
            rd_value[clc_pkg::CTRL_FALL_BIT] = s_q.fall_irq_en;
            rd_value[2:0] = s_q.function_select;
        end else if (PADDR == clc_pkg::OFS_POLARITY) begin
            // [R15] bits 6 to 4 read zero
            rd_value[clc_pkg::POL_RESULT_BIT] = s_q.result_invert;
            rd_value[3:0] = s_q.gate_invert;
        end else if (PADDR >= clc_pkg::OFS_INPUT_SEL0
                && PADDR < clc_pkg::OFS_GATE_SEL0) begin
            // [R15] selector bits 7 to 6 read zero
            rd_value[5:0] = s_q.input_source[idx];
        end else if (PADDR >= clc_pkg::OFS_GATE_SEL0
                && PADDR < clc_pkg::OFS_IRQ_STATUS) begin
            rd_value[7:0] = s_q.gate_select[idx];
        end else if (PADDR == clc_pkg::OFS_IRQ_STATUS) begin
            rd_value[clc_pkg::STAT_FLAG_BIT] = s_q.cell_irq_flag;
        end else begin
            hit = 1'b0;
        end

        // apb answer one wait state after the access phase opens
        s_d.ready = access_phase & ~s_q.ready;
        if (access_phase && !s_q.ready) begin
            s_d.rdata = PWRITE ? 32'h0000_0000 : rd_value;
            s_d.slverr = ~hit;
        end else begin
            s_d.slverr = 1'b0;
        end

        // [R23] write applied at the completing edge
        if (do_write && hit) begin
            if (PADDR == clc_pkg::OFS_CONTROL) begin
                s_d.cell_on = wbyte[clc_pkg::CTRL_ON_BIT];
                s_d.rise_irq_en = wbyte[clc_pkg::CTRL_RISE_BIT];
                s_d.fall_irq_en = wbyte[clc_pkg::CTRL_FALL_BIT];
                s_d.function_select = clc_pkg::clc_func_t'(wbyte[2:0]);
            end else if (PADDR == clc_pkg::OFS_POLARITY) begin
                s_d.result_invert = wbyte[clc_pkg::POL_RESULT_BIT];
                s_d.gate_invert = wbyte[3:0];
            end else if (PADDR >= clc_pkg::OFS_INPUT_SEL0
                    && PADDR < clc_pkg::OFS_GATE_SEL0) begin
                s_d.input_source[idx] = wbyte[5:0];
            end else if (PADDR >= clc_pkg::OFS_GATE_SEL0
                    && PADDR < clc_pkg::OFS_IRQ_STATUS) begin
                s_d.gate_select[idx] = wbyte;
            end else begin
                flag_clear = wbyte[clc_pkg::STAT_FLAG_BIT];
            end
        end

        // [R01] cell off gives logic zero
        // [R13] result inversion after function
        // [R22] inversion change seen as edge
        if (s_q.cell_on) begin
            out_next = link.result ^ s_q.result_invert;
        end else begin
            out_next = 1'b0;
        end
        s_d.cell_result = out_next;

        // [R23] compare with registered output
        // [R03] rising edge detect
        rise_evt = s_q.rise_irq_en & out_next & ~s_q.cell_result;
        // [R04] falling edge detect
        fall_evt = s_q.fall_irq_en & ~out_next & s_q.cell_result;

        if (flag_clear) begin
            s_d.cell_irq_flag = 1'b0;
        end
        // [R21] edge during clear keeps flag
        if (rise_evt || fall_evt) begin
            s_d.cell_irq_flag = 1'b1;
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (SRST) begin
            // [R20] selectors and gate settings kept
            s_q <= s_d;
            s_q.cell_on <= clc_pkg::CONTROL_RESET[clc_pkg::CTRL_ON_BIT];
            s_q.rise_irq_en <= clc_pkg::CONTROL_RESET[clc_pkg::CTRL_RISE_BIT];
            s_q.fall_irq_en <= clc_pkg::CONTROL_RESET[clc_pkg::CTRL_FALL_BIT];
            s_q.function_select <= clc_pkg::clc_func_t'(clc_pkg::CONTROL_RESET[2:0]);
            s_q.result_invert <= clc_pkg::POL_RESULT_RESET;
            s_q.cell_result <= 1'b0;
            s_q.cell_irq_flag <= 1'b0;
            s_q.rdata <= 32'h0000_0000;
            s_q.ready <= 1'b0;
            s_q.slverr <= 1'b0;
        end else begin
            s_q <= s_d;
        end
    end

    assign PRDATA = s_q.rdata;
    assign PREADY = s_q.ready;
    assign PSLVERR = s_q.slverr;
    assign CELL_OUTPUT_SIGNAL = s_q.cell_result;
    assign CELL_IRQ_FLAG = s_q.cell_irq_flag;

endmodule

// ===== tb/clc_src_model.sv
/* Far-side source model: registers the 64 source levels the bench asks for.
   Assumes the bench changes next_val just after REF_CLK edges. */
`timescale 1ns/100ps
module clc_src_model (
    input wire logic REF_CLK,
    input wire logic [63:0] next_val,
    output logic [63:0] src
);
    always_ff @(posedge REF_CLK) begin
        src <= next_val;
    end
endmodule

// ===== tb/clc_cell_chk.sv
/* Port checker for clc_cell.
   Assumes one REF_CLK domain and SRST synchronous, active high. */
`timescale 1ns/100ps
module clc_cell_chk (
    input wire logic REF_CLK,
    input wire logic SRST,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic [3:0] PSTRB,
    input wire logic [31:0] PRDATA,
    input wire logic PREADY,
    input wire logic PSLVERR,
    input wire logic [63:0] SRC_IN,
    input wire logic CELL_OUTPUT_SIGNAL,
    input wire logic CELL_IRQ_FLAG
);
    default clocking @(posedge REF_CLK); endclocking
    default disable iff (SRST);
    sequence s_done;
        PSEL && PENABLE && PREADY;
    endsequence
    sequence s_rd;
        s_done ##0 !PWRITE && !PSLVERR;
    endsequence
    chk_ready_pulse: assert property (PREADY |-> PSEL && PENABLE ##1 !PREADY)
        else $error("ready not a single pulse");
    chk_err_misalign: assert property (s_done ##0 PADDR[1:0] != 2'b00 |-> PSLVERR)
        else $error("misaligned access accepted");
    chk_upper_zero: assert property (s_rd |-> PRDATA[31:8] == 24'h0)
        else $error("upper read bits set");
    chk_ctl_unused: assert property (s_rd ##0 PADDR == clc_pkg::OFS_CONTROL |-> !PRDATA[6])
        else $error("control bit 6 set");
    chk_off_result: assert property (s_rd ##0 PADDR == 8'h00 && !PRDATA[7] |-> !PRDATA[5])
        else $error("result set while off");
    chk_pol_unused: assert property (s_rd ##0 PADDR == 8'h04 |-> PRDATA[6:4] == 3'h0)
        else $error("polarity spare bits set");
    chk_sel_unused: assert property (s_rd ##0 PADDR >= 8'h08 && PADDR < 8'h18
        |-> PRDATA[7:6] == 2'h0)
        else $error("selector spare bits set");
    chk_flag_cause: assert property ($rose(CELL_IRQ_FLAG) |-> $changed(CELL_OUTPUT_SIGNAL))
        else $error("flag set without output edge");
    chk_flag_clear: assert property ($fell(CELL_IRQ_FLAG) |-> $past(SRST)
        || $past(PREADY && PWRITE && PADDR == clc_pkg::OFS_IRQ_STATUS && PWDATA[0]))
        else $error("flag dropped without clear");
    chk_off_zero: assert property (s_done ##0 PWRITE && PADDR == 8'h00 && PSTRB[0]
        && !PWDATA[7] |-> ##[1:3] !CELL_OUTPUT_SIGNAL)
        else $error("output not zero when off");
    chk_reset_clear: assert property (disable iff (1'b0)
        SRST |=> !CELL_IRQ_FLAG && !CELL_OUTPUT_SIGNAL && !PREADY)
        else $error("reset left outputs set");
endmodule
bind clc_cell clc_cell_chk u_clc_cell_chk (.REF_CLK(REF_CLK), .SRST(SRST), .PSEL(PSEL),
    .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PSTRB(PSTRB),
    .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .SRC_IN(SRC_IN),
    .CELL_OUTPUT_SIGNAL(CELL_OUTPUT_SIGNAL), .CELL_IRQ_FLAG(CELL_IRQ_FLAG));

// ===== tb/clc_cell_tb.sv
/* Self-checking bench for clc_cell with a reference model of the cell.
   Assumes the source model and the checker are compiled before it. */
`timescale 1ns/100ps
module clc_cell_tb;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [63:0] src_next = 64'h0;
    logic [63:0] src;
    logic [31:0] prdata, rd;
    logic pready, pslverr, cell_out, cell_flag, err, q, g0p, eo, ef;
    logic [31:0] lf = 32'h20;
    logic [7:0] sel [4];
    logic [7:0] gls [4];
    logic [7:0] pol, ctl;
    int mismatches = 0;
    int n_compared = 0;
    always #12.5 clk = ~clk;
    clc_cell u_clc_cell (.REF_CLK(clk), .SRST(srst), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PSTRB(4'hf), .PRDATA(prdata),
        .PREADY(pready), .PSLVERR(pslverr), .SRC_IN(src), .CELL_OUTPUT_SIGNAL(cell_out),
        .CELL_IRQ_FLAG(cell_flag));
    clc_src_model u_clc_src_model (.REF_CLK(clk), .next_val(src_next), .src(src));
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic [7:0] ra(input logic [7:0] b, input int i);
        return 8'(b + 8'(4 * i));
    endfunction
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) mismatches++;
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic settle(input logic [63:0] s);
        logic [3:0] d, g;
        logic [7:0] t;
        logic o;
        src_next <= s;
        repeat (4) @(posedge clk);
        for (int i = 0; i < 4; i++) d[i] = s[sel[i][5:0]];
        t = {d[3], ~d[3], d[2], ~d[2], d[1], ~d[1], d[0], ~d[0]};
        for (int i = 0; i < 4; i++) g[i] = (|(gls[i] & t)) ^ pol[i];
        if (!ctl[7]) q = 1'b0;
        else case (ctl[2:0])
            3'h0: q = (g[0] & g[1]) | (g[2] & g[3]);
            3'h1: q = (g[0] | g[1]) ^ (g[2] | g[3]);
            3'h2: q = &g;
            3'h3: q = (g[0] | g[1]) ? 1'b1 : (g[2] | g[3]) ? 1'b0 : q;
            3'h4: q = g[2] ? 1'b0 : g[3] ? 1'b1 : (g[0] & ~g0p) ? g[1] : q;
            3'h5: q = g[2] ? 1'b0 : (g[0] & ~g0p) ? g[1] & g[3] : q;
            3'h6: q = g[2] ? 1'b0 : (g[0] & ~g0p) ? (g[1] & ~q) | (~g[3] & q) : q;
            default: q = g[2] ? 1'b0 : g[3] ? 1'b1 : g[0] ? g[1] : q;
        endcase
        g0p = g[0];
        o = ctl[7] & (q ^ pol[7]);
        if (o !== eo && (o ? ctl[4] : ctl[3])) ef = 1'b1;
        eo = o;
        check("cell output", {31'h0, cell_out}, {31'h0, eo});
        check("irq flag", {31'h0, cell_flag}, {31'h0, ef});
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        apb(1'b1, a, {24'h0, d});
        if (a == clc_pkg::OFS_CONTROL) ctl = d & 8'h9f;
        if (a == clc_pkg::OFS_POLARITY) pol = d & 8'h8f;
        for (int i = 0; i < 4; i++) begin
            if (a == ra(clc_pkg::OFS_INPUT_SEL0, i)) sel[i] = d & 8'h3f;
            if (a == ra(clc_pkg::OFS_GATE_SEL0, i)) gls[i] = d;
        end
        if (a == clc_pkg::OFS_IRQ_STATUS && d[0]) ef = 1'b0;
        settle(src_next);
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [7:0] e, input logic er);
        apb(1'b0, a, 32'h0);
        check("read data", rd, {24'h0, e});
        check("slave error", {31'h0, err}, {31'h0, er});
    endtask
    task automatic close_out;
        if (mismatches == 0 && n_compared > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        repeat (40000) @(posedge clk);
        mismatches++;
        close_out;
    end
    initial begin
        logic [63:0] s;
        {ctl, pol, q, g0p, eo, ef} = '0;
        repeat (3) @(posedge clk);
        srst <= 1'b0;
        rdchk(clc_pkg::OFS_CONTROL, 8'h00, 1'b0);
        rdchk(8'h2c, 8'h00, 1'b1);
        rdchk(8'h05, 8'h00, 1'b1);
        for (int m = 0; m < 8; m++) begin
            wr(clc_pkg::OFS_CONTROL, 8'h00);
            wr(clc_pkg::OFS_IRQ_STATUS, 8'h01);
            for (int i = 0; i < 4; i++) begin
                lf = lfsr(lf);
                wr(ra(clc_pkg::OFS_INPUT_SEL0, i), lf[7:0] | 8'hc0);
                wr(ra(clc_pkg::OFS_GATE_SEL0, i), m < 3 ? lf[15:8] : 8'(8'h02 << (2 * i)));
                rdchk(ra(clc_pkg::OFS_INPUT_SEL0, i), sel[i], 1'b0);
                rdchk(ra(clc_pkg::OFS_GATE_SEL0, i), gls[i], 1'b0);
            end
            wr(clc_pkg::OFS_POLARITY, (lf[23:16] | 8'h70) & (m < 3 ? 8'hff : 8'hfe));
            rdchk(clc_pkg::OFS_POLARITY, pol, 1'b0);
            settle(64'h0);
            wr(clc_pkg::OFS_CONTROL, {4'hf, lf[24], 3'(m)});
            for (int k = 0; k < 8; k++) begin
                lf = lfsr(lf);
                s = {lf, lfsr(lf)};
                if (m == 7) s[sel[3][5:0]] = 1'b0;
                settle(s);
                if (k == 3) rdchk(8'h00, {ctl[7], 1'b0, eo, ctl[4:0]}, 1'b0);
            end
            wr(clc_pkg::OFS_POLARITY, pol ^ 8'h80);
        end
        srst <= 1'b1;
        repeat (3) @(posedge clk);
        srst <= 1'b0;
        {ctl, pol[7], q, eo, ef} = '0;
        settle(src_next);
        rdchk(clc_pkg::OFS_CONTROL, 8'h00, 1'b0);
        rdchk(clc_pkg::OFS_INPUT_SEL0, sel[0], 1'b0);
        close_out;
    end
endmodule
